//--- bench/pfo_fault_ctrl_sva.sv
// Purpose: Bus and pin checks of the fault override block
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the top ports
`timescale 1ns/1ps
module pfo_fault_ctrl_chk (
    input wire logic clock,            // Clock
    input wire logic rst_b,            // Reset, active low
    input wire logic s_axi_awready,    // Write address ready
    input wire logic s_axi_wready,     // Write data ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid,     // Write response valid
    input wire logic s_axi_bready,     // Write response ready
    input wire logic s_axi_arready,    // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid,     // Read data valid
    input wire logic s_axi_rready,     // Read data ready
    input wire logic pwm_high_in,      // Generator high drive
    input wire logic pwm_low_in,       // Generator low drive
    input wire logic pwm_high_out,     // High pin drive
    input wire logic pwm_low_out,      // Low pin drive
    input wire logic pwm_timebase_on,  // Time-base enable
    input wire logic irq               // Interrupt
);
    logic wrote_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Until the first write the reset mode is off, so pins follow the generator
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrote_r <= 1'b0;
        end else if (s_axi_awready) begin
            wrote_r <= 1'b1;
        end
    end
    AST_AW_W_PAIR: assert property (s_axi_awready == s_axi_wready)
        else $error("write ready channels differ");
    AST_AW_TO_B: assert property (s_axi_awready |=> !s_axi_awready && s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    AST_AR_TO_R: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_PASS_OFF: assert property (!wrote_r && $past(rst_b) |->
        pwm_high_out == $past(pwm_high_in) && pwm_low_out == $past(pwm_low_in))
        else $error("pins not following generator in off mode");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_b |=> !pwm_timebase_on && !irq)
        else $error("outputs active after reset");
endmodule
bind pfo_fault_ctrl pfo_fault_ctrl_chk i_chk (.clock(clock), .rst_b(rst_b),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in), .pwm_high_out(pwm_high_out),
    .pwm_low_out(pwm_low_out), .pwm_timebase_on(pwm_timebase_on), .irq(irq));

//--- bench/pfo_fault_src.sv
// Purpose: Model of the external fault pins, comparators and period boundary
// Assumes: The bench sets the wanted raw levels
// Notes:   Levels are registered, as a synchronizer stage would be
`timescale 1ns/1ps
module pfo_fault_src (
    input wire logic clock,           // Clock
    input wire logic rst_b,           // Reset, active low
    input wire logic [8:0] lvl,       // Wanted levels: faults, comparators, default
    input wire logic tick,            // Request one period boundary
    output logic [3:0] fault_in,      // Fault pins
    output logic [3:0] cmp_in,        // Comparator outputs
    output logic fault32_in,          // Default fault source
    output logic pwm_period_end       // Period boundary pulse
);
    // One flop stage so levels change just after an edge
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            {fault32_in, cmp_in, fault_in} <= 9'h000;
            pwm_period_end <= 1'b0;
        end else begin
            {fault32_in, cmp_in, fault_in} <= lvl;
            pwm_period_end <= tick;
        end
    end
endmodule

//--- bench/testbench.sv
// Purpose: Register, lock and override tests of the fault override block
// Assumes: AXI4-Lite master tasks, 4 ns clock
// Notes:   Override values are high 1, low 0, opposite to the generator drive
`timescale 1ns/1ps
`include "pfo_regs.svh"
module testbench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ph, pl, tbon, irq, pend, f32;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] fin, cin;
    logic tick = 1'b0, hin = 1'b0, lin = 1'b1;
    logic [8:0] lvl = 9'h000;
    logic [4:0] src_tab [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h1f};
    int err_count = 0;
    int checks = 0;
    always #2 clock = ~clock;
    pfo_fault_src i_pfo_fault_src (.clock(clock), .rst_b(rst_b), .lvl(lvl), .tick(tick),
        .fault_in(fin), .cmp_in(cin), .fault32_in(f32), .pwm_period_end(pend));
    pfo_fault_ctrl i_pfo_fault_ctrl (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault_in(fin),
        .cmp_in(cin), .fault32_in(f32), .pwm_period_end(pend), .pwm_high_in(hin),
        .pwm_low_in(lin), .pwm_high_out(ph), .pwm_low_out(pl), .pwm_timebase_on(tbon),
        .irq(irq));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("Mismatches %0d in %0d checks", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // Looks just before the edge, so the answer is taken at that edge
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        @(negedge clock);
        while (s !== 1'b1) begin
            n++;
            if (n > 50) begin
                chk("handshake", 32'h1, 32'h0);
                test_done();
            end
            @(negedge clock);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wait_hi(awready);
        @(posedge clock);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_hi(bvalid);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge clock);
        bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic [31:0] v;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hi(arready);
        @(posedge clock);
        arvalid <= 1'b0;
        wait_hi(rvalid);
        v = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge clock);
        rready <= 1'b0;
        @(posedge clock);
        if (er == `PFO_RESP_OKAY) begin
            chk(nm, e, v);
        end
    endtask
    // Pins after a settling wait of a few edges
    task automatic pins(input logic eh, input logic el);
        repeat (4) @(posedge clock);
        chk("pwm_high_out", {31'h0, eh}, {31'h0, ph});
        chk("pwm_low_out", {31'h0, el}, {31'h0, pl});
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd("fcl", `PFO_OFS_FCL, 32'hfb, `PFO_RESP_OKAY);
        rd("cfg", `PFO_OFS_CFG, 32'h1, `PFO_RESP_OKAY);
        rd("ioctl", `PFO_OFS_IOCTL, 32'h0, `PFO_RESP_OKAY);
        rd("unmapped", 8'h20, 32'h0, `PFO_RESP_SLVERR);
        wr(`PFO_OFS_IRQ_EN, 32'h7, `PFO_RESP_OKAY);
        wr(`PFO_OFS_FCL, 32'h01, `PFO_RESP_OKAY);
        rd("fcl locked", `PFO_OFS_FCL, 32'hfb, `PFO_RESP_OKAY);
        rd("irq status", `PFO_OFS_IRQ_ST, 32'h2, `PFO_RESP_OKAY);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`PFO_OFS_IRQ_EN, 32'h0, `PFO_RESP_OKAY);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`PFO_OFS_IRQ_CLR, 32'h7, `PFO_RESP_OKAY);
        rd("irq cleared", `PFO_OFS_IRQ_ST, 32'h0, `PFO_RESP_OKAY);
        // A read between the keys abandons the unlock
        wr(`PFO_OFS_KEY, `PFO_KEY1, `PFO_RESP_OKAY);
        rd("fcl", `PFO_OFS_FCL, 32'hfb, `PFO_RESP_OKAY);
        wr(`PFO_OFS_KEY, `PFO_KEY2, `PFO_RESP_OKAY);
        wr(`PFO_OFS_FCL, 32'h01, `PFO_RESP_OKAY);
        rd("fcl abandoned", `PFO_OFS_FCL, 32'hfb, `PFO_RESP_OKAY);
        rd("irq abandon", `PFO_OFS_IRQ_ST, 32'h6, `PFO_RESP_OKAY);
        wr(`PFO_OFS_IRQ_CLR, 32'h7, `PFO_RESP_OKAY);
        wr(`PFO_OFS_KEY, `PFO_KEY1, `PFO_RESP_OKAY);
        wr(`PFO_OFS_KEY, `PFO_KEY2, `PFO_RESP_OKAY);
        wr(`PFO_OFS_IOCTL, 32'h2, `PFO_RESP_OKAY);
        rd("ioctl", `PFO_OFS_IOCTL, 32'h2, `PFO_RESP_OKAY);
        wr(`PFO_OFS_CFG, 32'h0, `PFO_RESP_OKAY);
        // Each of the nine mapped source codes, mode off: seen as asserted, no override
        for (int i = 0; i < 9; i++) begin
            wr(`PFO_OFS_FCL, {24'h0, src_tab[i], 3'h3}, `PFO_RESP_OKAY);
            lvl <= 9'h001 << i;
            repeat (3) @(posedge clock);
            rd("state", `PFO_OFS_STATE, 32'h2, `PFO_RESP_OKAY);
            lvl <= 9'h000;
        end
        wr(`PFO_OFS_FCL, 32'h01, `PFO_RESP_OKAY);
        lvl <= 9'h001;
        pins(1'b1, 1'b0);
        lvl <= 9'h000;
        pins(1'b1, 1'b0);
        tick <= 1'b1;
        @(posedge clock);
        tick <= 1'b0;
        pins(1'b0, 1'b1);
        wr(`PFO_OFS_FCL, 32'h44, `PFO_RESP_OKAY);
        pins(1'b1, 1'b0);
        lvl <= 9'h010;
        tick <= 1'b1;
        @(posedge clock);
        tick <= 1'b0;
        pins(1'b1, 1'b0);
        wr(`PFO_OFS_FCL, 32'h47, `PFO_RESP_OKAY);
        pins(1'b0, 1'b1);
        lvl <= 9'h000;
        pins(1'b0, 1'b1);
        rd("irq onset", `PFO_OFS_IRQ_ST, 32'h1, `PFO_RESP_OKAY);
        wr(`PFO_OFS_CFG, 32'h2, `PFO_RESP_OKAY);
        chk("pwm_timebase_on", 32'h1, {31'h0, tbon});
        test_done();
    end
endmodule

//--- verilog/pfo_fault_ctrl.sv
// Purpose: Fault override of a PWM generator with key-guarded control writes
// Assumes: Single 250 MHz clock, synchronous active-low reset, AXI4-Lite slave
// Notes:   All outputs come straight from flip-flops
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pfo_regs.svh"
module pfo_fault_ctrl #(
    parameter int NUM_FLT = 4,
    parameter int NUM_CMP = 4
) (
    input wire logic clock,                  // 250 MHz clock
    input wire logic rst_b,                  // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr,     // Write address
    input wire logic s_axi_awvalid,          // Write address valid
    output logic s_axi_awready,              // Write address ready
    input wire logic [31:0] s_axi_wdata,     // Write data
    input wire logic [3:0] s_axi_wstrb,      // Write strobes
    input wire logic s_axi_wvalid,           // Write data valid
    output logic s_axi_wready,               // Write data ready
    output logic [1:0] s_axi_bresp,          // Write response
    output logic s_axi_bvalid,               // Write response valid
    input wire logic s_axi_bready,           // Write response ready
    input wire logic [7:0] s_axi_araddr,     // Read address
    input wire logic s_axi_arvalid,          // Read address valid
    output logic s_axi_arready,              // Read address ready
    output logic [31:0] s_axi_rdata,         // Read data
    output logic [1:0] s_axi_rresp,          // Read response
    output logic s_axi_rvalid,               // Read data valid
    input wire logic s_axi_rready,           // Read data ready
    input wire logic [NUM_FLT-1:0] fault_in, // Fault pins
    input wire logic [NUM_CMP-1:0] cmp_in,   // Comparator outputs
    input wire logic fault32_in,             // Default fault source
    input wire logic pwm_period_end,         // One-cycle pulse at each PWM period boundary
    input wire logic pwm_high_in,            // Generator high-side drive
    input wire logic pwm_low_in,             // Generator low-side drive
    output logic pwm_high_out,               // High-side pin drive
    output logic pwm_low_out,                // Low-side pin drive
    output logic pwm_timebase_on,            // Time-base enable to the generator
    output logic irq                         // Level interrupt
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    pfo_pkg::pfo_fcl_t fcl_r;
    pfo_pkg::pfo_pair_t fault_override_value_r;
    pfo_pkg::pfo_lock_st_t lk_r;
    logic [1:0] cfg_r;
    logic ovr_r;
    logic [`PFO_EV_W-1:0] irq_st_r;
    logic [`PFO_EV_W-1:0] irq_en_r;
    logic aw_rdy_r;
    logic ar_rdy_r;
    logic [7:0] rd_addr_r;

    // ----------------------------------------------------------------
    // Fault source selection
    // ----------------------------------------------------------------
    wire logic fault_asserted;

    pfo_fault_sel #(
        .NUM_FLT(NUM_FLT),
        .NUM_CMP(NUM_CMP)
    ) u_sel (
        .fault_in(fault_in),
        .cmp_in(cmp_in),
        .fault32_in(fault32_in),
        .src(fcl_r.src),
        .pol(fcl_r.pol),
        .asserted(fault_asserted)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Write and read are never taken in the same cycle, so each access
    // is seen alone by the unlock sequencer
    wire logic wr_take;
    wire logic rd_take;
    wire logic wr_fire;
    wire logic rd_fire;
    wire logic any_access;
    wire logic [15:0] wd16;
    wire logic wr_fcl;
    wire logic wr_ioctl;
    wire logic wr_key;
    wire logic wr_cfg;
    wire logic wr_clr;
    wire logic wr_en;
    wire logic wr_mapped;
    wire logic rd_mapped;
    wire logic wr_protected;
    wire logic locked;
    wire logic unlocked_now;
    wire logic prot_ok;

    assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~aw_rdy_r;
    assign rd_take = s_axi_arvalid & ~s_axi_rvalid & ~ar_rdy_r & ~wr_take & ~aw_rdy_r;
    assign wr_fire = aw_rdy_r;
    assign rd_fire = ar_rdy_r;
    assign any_access = wr_fire | rd_fire;
    assign wd16 = s_axi_wdata[15:0];
    assign wr_fcl = wr_fire & (s_axi_awaddr == `PFO_OFS_FCL);
    assign wr_ioctl = wr_fire & (s_axi_awaddr == `PFO_OFS_IOCTL);
    assign wr_key = wr_fire & (s_axi_awaddr == `PFO_OFS_KEY);
    assign wr_cfg = wr_fire & (s_axi_awaddr == `PFO_OFS_CFG);
    // Strobe folded in here so status, enable and the interrupt output agree
    assign wr_clr = wr_fire & s_axi_wstrb[0] & (s_axi_awaddr == `PFO_OFS_IRQ_CLR);
    assign wr_en = wr_fire & s_axi_wstrb[0] & (s_axi_awaddr == `PFO_OFS_IRQ_EN);
    assign wr_mapped = (s_axi_awaddr[7:2] <= 6'h07) & (s_axi_awaddr[1:0] == 2'h0);
    assign rd_mapped = (rd_addr_r[7:2] <= 6'h07) & (rd_addr_r[1:0] == 2'h0);
    assign wr_protected = wr_fcl | wr_ioctl;
    assign locked = cfg_r[`PFO_CFG_LOCK];
    assign unlocked_now = (lk_r == pfo_pkg::LK_OPEN);
    // While locked, a protected write lands only straight after the key pair
    assign prot_ok = ~locked | unlocked_now;

    // ----------------------------------------------------------------
    // Unlock sequencer
    // ----------------------------------------------------------------
    pfo_pkg::pfo_lock_st_t lk_nxt;
    logic lk_abort;

    always_comb begin
        lk_nxt = lk_r;
        lk_abort = 1'b0;
        if (any_access) begin
            case (lk_r)
                pfo_pkg::LK_IDLE: begin
                    lk_nxt = (wr_key && wd16 == `PFO_KEY1) ? pfo_pkg::LK_KEY1
                                                           : pfo_pkg::LK_IDLE;
                end
                pfo_pkg::LK_KEY1: begin
                    // Second key must follow at once
                    lk_nxt = (wr_key && wd16 == `PFO_KEY2) ? pfo_pkg::LK_OPEN
                                                           : pfo_pkg::LK_IDLE;
                    lk_abort = ~(wr_key && wd16 == `PFO_KEY2);
                end
                pfo_pkg::LK_OPEN: begin
                    // One access only: anything but a protected write wastes it
                    lk_nxt = pfo_pkg::LK_IDLE;
                    lk_abort = ~wr_protected;
                end
                default: begin
                    lk_nxt = pfo_pkg::LK_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Override state
    // ----------------------------------------------------------------
    wire logic fault_on;
    wire logic ovr_clear;
    wire logic ovr_nxt;
    wire logic [`PFO_EV_W-1:0] ev;
    wire logic [`PFO_EV_W-1:0] irq_st_nxt;

    // Mode 11 ignores the input; reserved 10 is treated the same
    assign fault_on = fault_asserted & ~fcl_r.mode[1];
    // Latched mode clears only on a control write while the fault is gone;
    // cycle mode clears at the period boundary once it is gone
    assign ovr_clear = (fcl_r.mode == `PFO_MODE_LATCH) ? (wr_fcl & prot_ok)
                     : (fcl_r.mode == `PFO_MODE_CYCLE) ? pwm_period_end
                     : 1'b1;
    assign ovr_nxt = fault_on | (ovr_r & ~ovr_clear);

    // Events: override onset, refused protected write, abandoned unlock
    assign ev = {lk_abort, wr_protected & ~prot_ok, ovr_nxt & ~ovr_r};
    // Set wins over a clear in the same cycle
    assign irq_st_nxt = (irq_st_r & ~(wr_clr ? s_axi_wdata[`PFO_EV_W-1:0] : '0)) | ev;

    // Override and pin drive
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ovr_r <= 1'b0;
            pwm_high_out <= 1'b0;
            pwm_low_out <= 1'b0;
        end else begin
            ovr_r <= ovr_nxt;
            pwm_high_out <= ovr_nxt ? fault_override_value_r.high : pwm_high_in;
            pwm_low_out <= ovr_nxt ? fault_override_value_r.low : pwm_low_in;
        end
    end

    // Control registers; polarity and source stay writable while running,
    // software must keep the time base off while changing them
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fcl_r <= pfo_pkg::pfo_fcl_t'(`PFO_FCL_RST);
            fault_override_value_r <= pfo_pkg::pfo_pair_t'(`PFO_IOCTL_RST);
            cfg_r <= `PFO_CFG_RST;
            lk_r <= pfo_pkg::LK_IDLE;
        end else begin
            lk_r <= lk_nxt;
            if (wr_fcl && prot_ok && s_axi_wstrb[0]) begin
                fcl_r <= pfo_pkg::pfo_fcl_t'(s_axi_wdata[`PFO_FCL_W-1:0]);
            end
            if (wr_ioctl && prot_ok && s_axi_wstrb[0]) begin
                fault_override_value_r <= pfo_pkg::pfo_pair_t'(s_axi_wdata[1:0]);
            end
            if (wr_cfg && s_axi_wstrb[0]) begin
                cfg_r <= s_axi_wdata[1:0];
            end
        end
    end

    // Interrupt status, enable and output
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_st_r <= '0;
            irq_en_r <= '0;
            irq <= 1'b0;
        end else begin
            irq_st_r <= irq_st_nxt;
            if (wr_en && s_axi_wstrb[0]) begin
                irq_en_r <= s_axi_wdata[`PFO_EV_W-1:0];
            end
            irq <= |(irq_st_nxt & (wr_en ? s_axi_wdata[`PFO_EV_W-1:0] : irq_en_r));
        end
    end

    // ----------------------------------------------------------------
    // Bus handshakes and read data
    // ----------------------------------------------------------------
    wire logic [31:0] rd_val;

    assign rd_val = (rd_addr_r == `PFO_OFS_FCL) ? {24'h000000, fcl_r}
                  : (rd_addr_r == `PFO_OFS_IOCTL) ? {30'h00000000, fault_override_value_r}
                  : (rd_addr_r == `PFO_OFS_CFG) ? {30'h00000000, cfg_r}
                  : (rd_addr_r == `PFO_OFS_STATE) ? {29'h00000000, unlocked_now,
                                                     fault_asserted, ovr_r}
                  : (rd_addr_r == `PFO_OFS_IRQ_ST) ? {29'h00000000, irq_st_r}
                  : (rd_addr_r == `PFO_OFS_IRQ_EN) ? {29'h00000000, irq_en_r}
                  : 32'h00000000;

    // Ready pulses one cycle after both channels are offered
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            aw_rdy_r <= 1'b0;
            ar_rdy_r <= 1'b0;
            rd_addr_r <= 8'h00;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PFO_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `PFO_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            aw_rdy_r <= wr_take;
            ar_rdy_r <= rd_take;
            if (rd_take) begin
                rd_addr_r <= s_axi_araddr;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `PFO_RESP_OKAY : `PFO_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_mapped ? `PFO_RESP_OKAY : `PFO_RESP_SLVERR;
                s_axi_rdata <= rd_val;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = aw_rdy_r;
    assign s_axi_wready = aw_rdy_r;
    assign s_axi_arready = ar_rdy_r;
    assign pwm_timebase_on = cfg_r[`PFO_CFG_TBON];

endmodule

//--- verilog/pfo_fault_sel.sv
// Purpose: Picks one fault source and applies the polarity selection
// Assumes: Fault and comparator levels are synchronous to the clock
// Notes:   Reserved source codes read as a zero level, which counts as asserted when pol is one
`timescale 1ns/1ps
module pfo_fault_sel #(
    parameter int NUM_FLT = 4,
    parameter int NUM_CMP = 4
) (
    input wire logic [NUM_FLT-1:0] fault_in, // Fault pins, raw level
    input wire logic [NUM_CMP-1:0] cmp_in,   // Comparator outputs, raw level
    input wire logic fault32_in,             // Default fault source
    input wire logic [4:0] src,              // Source code
    input wire logic pol,                    // 1 selects active-low
    output logic asserted                    // Selected source is active
);

    // ----------------------------------------------------------------
    // Source map
    // ----------------------------------------------------------------
    if (NUM_FLT > 8 || NUM_CMP > 8 || NUM_FLT < 1 || NUM_CMP < 1) begin : g_chk
        $error("pfo_fault_sel: source counts must be 1 to 8");
    end

    wire logic [31:0] src_vec;
    wire logic level;

    // Faults at codes 0.., comparators at 8.., the default at 31; the gaps
    // are size casts rather than replications so a full set of eight still fits
    assign src_vec = 32'(fault_in) | (32'(cmp_in) << 8) | {fault32_in, 31'h00000000};
    assign level = src_vec[src];
    // Active-low when pol is one, active-high otherwise
    assign asserted = level ^ pol;

endmodule

//--- verilog/pfo_pkg.sv
// Purpose: Types shared by the fault override block
// Assumes: Constants come from pfo_regs.svh
// Notes:   Nothing here is imported; users write pfo_pkg::name
package pfo_pkg;

    // Fault and current-limit control word
    typedef struct packed {
        logic [4:0] src;
        logic pol;
        logic [1:0] mode;
    } pfo_fcl_t;

    // Override values for the two outputs
    typedef struct packed {
        logic high;
        logic low;
    } pfo_pair_t;

    // Unlock sequencer states
    typedef enum logic [1:0] {
        LK_IDLE,
        LK_KEY1,
        LK_OPEN
    } pfo_lock_st_t;

endpackage

//--- verilog/pfo_regs.svh
// Purpose: Register offsets, field positions, reset values and keys of the fault override block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef PFO_REGS_SVH
`define PFO_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PFO_OFS_FCL      8'h00
`define PFO_OFS_IOCTL    8'h04
`define PFO_OFS_KEY      8'h08
`define PFO_OFS_CFG      8'h0c
`define PFO_OFS_STATE    8'h10
`define PFO_OFS_IRQ_ST   8'h14
`define PFO_OFS_IRQ_CLR  8'h18
`define PFO_OFS_IRQ_EN   8'h1c

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define PFO_FCL_W        8
`define PFO_MODE_LATCH   2'h0
`define PFO_MODE_CYCLE   2'h1
`define PFO_MODE_RSVD    2'h2
`define PFO_MODE_OFF     2'h3
`define PFO_CFG_LOCK     0
`define PFO_CFG_TBON     1
`define PFO_EV_W         3

// ----------------------------------------------------------------
// Reset values and unlock keys
// ----------------------------------------------------------------
`define PFO_FCL_RST      8'hfb
`define PFO_IOCTL_RST    2'h0
`define PFO_CFG_RST      2'h1
`define PFO_KEY1         16'habcd
`define PFO_KEY2         16'h4321
`define PFO_RESP_OKAY    2'h0
`define PFO_RESP_SLVERR  2'h2

`endif
